// *** hw/framer_status_pkg.sv ***
// constants, types and register map of the framer alarm status register bank
package framer_status_pkg;

    // ****************************************************************
    // register map: word index, byte address is four times the index
    // ****************************************************************
    localparam int         ADR_W         = 8;
    localparam logic [5:0] IDX_IRQ_CTRL  = 6'h02;
    localparam logic [5:0] IDX_MAINT     = 6'h10;
    localparam logic [5:0] IDX_CNT_IRQ   = 6'h11;
    localparam logic [5:0] IDX_LINE_MODE = 6'h18;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;
    localparam logic [7:0] LINE_MODE_RST = 8'h00;
    localparam logic [7:0] MAINT_RST     = 8'h00;
    localparam logic [6:0] CNT_IRQ_RST   = 7'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MAINT_REFRAME  = 7;
    localparam int MAINT_FMT_LO   = 5;
    localparam int MAINT_IDLE     = 4;
    localparam int MAINT_YELLOW   = 3;
    localparam int MAINT_AIS      = 2;
    localparam int MAINT_OOF      = 1;
    localparam int MAINT_LOS      = 0;
    localparam int SHADOW_SRC_TOP = 4;
    localparam int IRQ_SHADOW     = 6;
    localparam int IRQ_W          = 7;
    localparam int CTRL_SHADOW_EN = 7;
    localparam int CTRL_CNT_EN_W  = 6;
    localparam int MODE_E3        = 0;

    // ****************************************************************
    // incoming format codes
    // ****************************************************************
    typedef enum logic [1:0] {
        FMT_M13     = 2'b00,
        FMT_CBIT    = 2'b01,
        FMT_SYNTRAN = 2'b10
    } fmt_e;

    // ****************************************************************
    // alarm timing and thresholds
    // ****************************************************************
    localparam int         LOS_CYCLES   = 175;
    localparam int         LOS_TOL      = 75;
    localparam int         DENS_DS3_PCT = 33;
    localparam int         DENS_E3_PCT  = 25;
    localparam int         LOS_CNT_W    = 8;
    localparam logic [7:0] LOS_LAST     = 8'(LOS_CYCLES - 1);
    localparam logic [7:0] DS3_ONES_MIN = 8'((LOS_CYCLES * DENS_DS3_PCT + 99) / 100);
    localparam logic [7:0] E3_ONES_MIN  = 8'((LOS_CYCLES * DENS_E3_PCT + 99) / 100);
    localparam logic [4:0] OOF_F_ERRS   = 5'h03;
    localparam int         OOF_F_WIN    = 16;
    localparam logic [1:0] OOF_M_ERRS   = 2'h2;
    localparam logic [2:0] OOF_FAS_LAST = 3'h3;
    localparam int         E3_AIS_ONES  = 1024;

    // ****************************************************************
    // state machines
    // ****************************************************************
    typedef enum logic {
        LOS_OK   = 1'b0,
        LOS_LOST = 1'b1
    } los_state_e;

    typedef enum logic {
        IN_FRAME = 1'b0,
        HUNT     = 1'b1
    } frame_state_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic f_stb;
        logic f_err;
        logic m_stb;
        logic m_err;
        logic x1;
        logic x2;
        logic aic;
        logic par_ok;
        logic c_all_zero;
        logic c_sf3_zero;
        logic pay_stb;
        logic pay_bit;
        logic pay_first;
        logic fas_stb;
        logic fas_err;
        logic a_stb;
        logic a_bit;
        logic dat_stb;
        logic dat_bit;
        logic sync_found;
    } frm_ev_s;

    typedef struct packed {
        logic lcv;
        logic febe;
        logic pth;
        logic ferr;
        logic dgr;
        logic par;
    } cnt_ev_s;

endpackage

// *** hw/framer_alarm_status_regs.sv ***
// maintenance status and counter interrupt status registers of the framer receiver
`timescale 1ns/1ps

module framer_alarm_status_regs #(
    parameter int E3_AIS_ONES = framer_status_pkg::E3_AIS_ONES
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst,
    input  wire logic                                 cyc_i,
    input  wire logic                                 stb_i,
    input  wire logic                                 we_i,
    input  wire logic [framer_status_pkg::ADR_W-1:0]  adr_i,
    input  wire logic [3:0]                           sel_i,
    input  wire logic [31:0]                          dat_i,
    output logic      [31:0]                          dat_o,
    output logic                                      ack_o,
    input  wire logic                                 rx_raw,
    input  wire framer_status_pkg::frm_ev_s           frm,
    input  wire framer_status_pkg::cnt_ev_s           cnt_evt,
    output logic                                      counter_irq_pin_n,
    output logic                                      reframe_start
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                              raw_s1_q;
    logic                              raw_s2_q;
    framer_status_pkg::los_state_e     los_state_q;
    framer_status_pkg::frame_state_e   frame_state_q;
    logic [7:0]                        zrun_q;
    logic [7:0]                        win_q;
    logic [7:0]                        ones_q;
    logic [7:0]                        ones_min;
    logic [15:0]                       ferr_hist_q;
    logic [1:0]                        merr_hist_q;
    logic [2:0]                        fas_run_q;
    logic                              oof_q;
    logic                              oof_hit;
    logic                              yel_raw_q;
    logic [1:0]                        phase_q;
    logic [1:0]                        ph;
    logic                              idle_miss_q;
    logic                              ais_miss_q;
    logic                              idle_q;
    logic                              ais_ds3_q;
    logic [15:0]                       ones_run_q;
    logic [1:0]                        aic_hist_q;
    logic [1:0]                        fmt;
    logic                              e3;
    logic                              ais;
    logic                              los;
    logic [7:0]                        maint_d;
    logic [7:0]                        maint_q;
    logic [7:0]                        irq_ctrl_q;
    logic [7:0]                        mode_q;
    logic [framer_status_pkg::IRQ_W-1:0] irq_q;
    logic [framer_status_pkg::IRQ_W-1:0] irq_set;
    logic [framer_status_pkg::IRQ_W-1:0] irq_en;
    logic                              shadow_set;
    logic                              req;
    logic                              rd_clr;
    logic [5:0]                        idx;
    logic [7:0]                        rd_byte;
    logic [31:0]                       dat_q;
    logic                              ack_q;
    logic                              cnt_irq_n_q;
    logic                              reframe_start_q;

    function automatic logic [4:0] ones16(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + 5'(v[i]);
        end
        return n;
    endfunction

    assign e3 = mode_q[framer_status_pkg::MODE_E3];

    // ****************************************************************
    // raw line synchroniser
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            raw_s1_q <= 1'b0;
            raw_s2_q <= 1'b0;
        end else begin
            raw_s1_q <= rx_raw;
            raw_s2_q <= raw_s1_q;
        end
    end

    // ****************************************************************
    // loss of signal
    // ****************************************************************
    assign ones_min = e3 ? framer_status_pkg::E3_ONES_MIN : framer_status_pkg::DS3_ONES_MIN;
    assign los      = (los_state_q == framer_status_pkg::LOS_LOST);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zrun_q <= 8'h00;
        end else if (raw_s2_q) begin
            zrun_q <= 8'h00;
        end else if (zrun_q != framer_status_pkg::LOS_LAST) begin
            zrun_q <= zrun_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            los_state_q <= framer_status_pkg::LOS_OK;
            win_q       <= 8'h00;
            ones_q      <= 8'h00;
        end else begin
            case (los_state_q)
                framer_status_pkg::LOS_OK: begin
                    win_q  <= 8'h00;
                    ones_q <= 8'h00;
                    if (zrun_q == framer_status_pkg::LOS_LAST && !raw_s2_q) begin
                        los_state_q <= framer_status_pkg::LOS_LOST;
                    end
                end
                default: begin
                    if (win_q == framer_status_pkg::LOS_LAST) begin
                        win_q  <= 8'h00;
                        ones_q <= 8'h00;
                        if (ones_q + 8'(raw_s2_q) >= ones_min) begin
                            los_state_q <= framer_status_pkg::LOS_OK;
                        end
                    end else begin
                        win_q  <= win_q + 8'h01;
                        ones_q <= ones_q + 8'(raw_s2_q);
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // out of frame and reframe
    // ****************************************************************
    always_comb begin
        oof_hit = 1'b0;
        if (frame_state_q == framer_status_pkg::IN_FRAME) begin
            if (!e3) begin
                if (frm.f_stb && ones16({ferr_hist_q[14:0], frm.f_err})
                        >= framer_status_pkg::OOF_F_ERRS) begin
                    oof_hit = 1'b1;
                end
                if (frm.m_stb && (2'(merr_hist_q[0]) + 2'(merr_hist_q[1]) + 2'(frm.m_err))
                        >= framer_status_pkg::OOF_M_ERRS) begin
                    oof_hit = 1'b1;
                end
            end else if (frm.fas_stb && frm.fas_err
                    && fas_run_q == framer_status_pkg::OOF_FAS_LAST) begin
                oof_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ferr_hist_q <= 16'h0000;
            merr_hist_q <= 2'h0;
            fas_run_q   <= 3'h0;
        end else if (frm.sync_found || oof_hit) begin
            ferr_hist_q <= 16'h0000;
            merr_hist_q <= 2'h0;
            fas_run_q   <= 3'h0;
        end else begin
            if (frm.f_stb) begin
                ferr_hist_q <= {ferr_hist_q[14:0], frm.f_err};
            end
            if (frm.m_stb) begin
                merr_hist_q <= {merr_hist_q[0], frm.m_err};
            end
            if (frm.fas_stb) begin
                fas_run_q <= frm.fas_err ? fas_run_q + 3'h1 : 3'h0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_state_q   <= framer_status_pkg::HUNT;
            oof_q           <= 1'b0;
            reframe_start_q <= 1'b0;
        end else begin
            reframe_start_q <= oof_hit;
            case (frame_state_q)
                framer_status_pkg::IN_FRAME: begin
                    if (oof_hit) begin
                        frame_state_q <= framer_status_pkg::HUNT;
                        oof_q         <= 1'b1;
                    end
                end
                default: begin
                    if (frm.sync_found) begin
                        frame_state_q <= framer_status_pkg::IN_FRAME;
                        oof_q         <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // payload pattern, idle, AIS, yellow, format
    // ****************************************************************
    assign ph = frm.pay_first ? 2'h0 : phase_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_q     <= 2'h0;
            idle_miss_q <= 1'b0;
            ais_miss_q  <= 1'b0;
        end else begin
            if (frm.pay_stb) begin
                phase_q <= ph + 2'h1;
            end
            if (frm.m_stb) begin
                idle_miss_q <= 1'b0;
                ais_miss_q  <= 1'b0;
            end else if (frm.pay_stb) begin
                idle_miss_q <= idle_miss_q | (frm.pay_bit != ~ph[1]);
                ais_miss_q  <= ais_miss_q | (frm.pay_bit != ~ph[0]);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_q     <= 1'b0;
            ais_ds3_q  <= 1'b0;
            yel_raw_q  <= 1'b0;
            aic_hist_q <= 2'h0;
        end else if (e3) begin
            idle_q    <= 1'b0;
            ais_ds3_q <= 1'b0;
            if (frm.a_stb) begin
                yel_raw_q <= frm.a_bit;
            end
        end else if (frm.m_stb) begin
            idle_q     <= (frame_state_q == framer_status_pkg::IN_FRAME) && frm.par_ok
                          && frm.c_sf3_zero && (frm.x1 == frm.x2) && !idle_miss_q;
            ais_ds3_q  <= (frame_state_q == framer_status_pkg::IN_FRAME) && frm.par_ok
                          && frm.c_all_zero && (frm.x1 == frm.x2) && !ais_miss_q;
            yel_raw_q  <= !frm.x1 && !frm.x2;
            aic_hist_q <= {aic_hist_q[0], frm.aic};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ones_run_q <= 16'h0000;
        end else if (frm.dat_stb) begin
            if (!frm.dat_bit) begin
                ones_run_q <= 16'h0000;
            end else if (ones_run_q != 16'(E3_AIS_ONES)) begin
                ones_run_q <= ones_run_q + 16'h0001;
            end
        end
    end

    always_comb begin
        if (e3) begin
            fmt = framer_status_pkg::FMT_M13;
        end else if (aic_hist_q == 2'h3) begin
            fmt = framer_status_pkg::FMT_CBIT;
        end else if (aic_hist_q == 2'h0) begin
            fmt = framer_status_pkg::FMT_SYNTRAN;
        end else begin
            fmt = framer_status_pkg::FMT_M13;
        end
    end

    assign ais = e3 ? (ones_run_q == 16'(E3_AIS_ONES)) : ais_ds3_q;

    always_comb begin
        maint_d = framer_status_pkg::MAINT_RST;
        maint_d[framer_status_pkg::MAINT_REFRAME] =
            (frame_state_q == framer_status_pkg::HUNT);
        maint_d[framer_status_pkg::MAINT_FMT_LO+:2] = fmt;
        maint_d[framer_status_pkg::MAINT_IDLE]      = idle_q;
        maint_d[framer_status_pkg::MAINT_YELLOW]    = yel_raw_q && !los && !oof_q && !ais;
        maint_d[framer_status_pkg::MAINT_AIS]       = ais;
        maint_d[framer_status_pkg::MAINT_OOF]       = oof_q;
        maint_d[framer_status_pkg::MAINT_LOS]       = los;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            maint_q <= framer_status_pkg::MAINT_RST;
        end else begin
            maint_q <= maint_d;
        end
    end

    // ****************************************************************
    // counter interrupt status
    // ****************************************************************
    assign shadow_set = |(maint_d[framer_status_pkg::SHADOW_SRC_TOP:0]
                        & ~maint_q[framer_status_pkg::SHADOW_SRC_TOP:0]);
    assign irq_set    = {shadow_set, cnt_evt};
    assign irq_en     = {irq_ctrl_q[framer_status_pkg::CTRL_SHADOW_EN],
                         irq_ctrl_q[framer_status_pkg::CTRL_CNT_EN_W-1:0]};

    generate
        for (genvar i = 0; i < framer_status_pkg::IRQ_W; i++) begin : g_irq
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    irq_q[i] <= framer_status_pkg::CNT_IRQ_RST[i];
                end else if (irq_set[i]) begin
                    irq_q[i] <= 1'b1;
                end else if (rd_clr) begin
                    irq_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_irq_n_q <= 1'b1;
        end else begin
            cnt_irq_n_q <= ~|(irq_q & irq_en);
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    assign req    = cyc_i && stb_i && !ack_q;
    assign idx    = adr_i[7:2];
    assign rd_clr = req && !we_i && (idx == framer_status_pkg::IDX_CNT_IRQ);

    always_comb begin
        if (idx == framer_status_pkg::IDX_MAINT) begin
            rd_byte = maint_q;
        end else if (idx == framer_status_pkg::IDX_CNT_IRQ) begin
            rd_byte = {1'b0, irq_q};
        end else if (idx == framer_status_pkg::IDX_IRQ_CTRL) begin
            rd_byte = irq_ctrl_q;
        end else if (idx == framer_status_pkg::IDX_LINE_MODE) begin
            rd_byte = mode_q;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= we_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ctrl_q <= framer_status_pkg::IRQ_CTRL_RST;
            mode_q     <= framer_status_pkg::LINE_MODE_RST;
        end else if (cyc_i && stb_i && ack_q && we_i && sel_i[0]) begin
            if (idx == framer_status_pkg::IDX_IRQ_CTRL) begin
                irq_ctrl_q <= dat_i[7:0];
            end else if (idx == framer_status_pkg::IDX_LINE_MODE) begin
                mode_q <= dat_i[7:0];
            end
        end
    end

    assign dat_o             = dat_q;
    assign ack_o             = ack_q;
    assign counter_irq_pin_n = cnt_irq_n_q;
    assign reframe_start     = reframe_start_q;

endmodule

// *** tb/line_model.sv ***
// far-end line model driving the raw receive pin
`timescale 1ns/1ps

module line_model (
    input  wire logic mclk,
    input  wire logic dead,
    output logic      rx_raw
);
    // dead line sits low; live line alternates, half ones density
    always_ff @(posedge mclk) begin
        rx_raw <= !dead && rx_raw !== 1'b1;
    end
endmodule

// *** tb/framer_status_chk.sv ***
// port assertions of the framer status register bank
`timescale 1ns/1ps

module framer_status_chk #(
    parameter int E3_AIS_ONES = 8
) (
    input wire logic                                mclk,
    input wire logic                                rst,
    input wire logic                                cyc_i,
    input wire logic                                stb_i,
    input wire logic                                we_i,
    input wire logic [framer_status_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0]                         dat_o,
    input wire logic                                ack_o,
    input wire framer_status_pkg::cnt_ev_s          cnt_evt,
    input wire logic                                counter_irq_pin_n,
    input wire logic                                reframe_start
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic take;
    logic rd11;
    assign take = cyc_i && stb_i && !ack_o;
    assign rd11 = take && !we_i && adr_i[7:2] == 6'h11;
    property p_ack_next; take |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; $rose(ack_o) |-> $past(take); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_hi_zero; ack_o |-> dat_o[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
    property p_wr_zero; take && we_i |=> dat_o == 32'h0; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write data");
    property p_irq7; rd11 |=> dat_o[7] == 1'b0; endproperty
    a_irq7: assert property (p_irq7) else $error("irq bit7 set");
    property p_par; cnt_evt.par ##1 !rd11 ##1 !rd11 ##1 rd11 |=> dat_o[0]; endproperty
    a_par: assert property (p_par) else $error("parity irq lost");
    property p_refr; reframe_start |=> !reframe_start; endproperty
    a_refr: assert property (p_refr) else $error("reframe long");
    c_wr: cover property (take && we_i);
    c_refr: cover property (reframe_start);
    c_pin: cover property (!counter_irq_pin_n);
endmodule

bind framer_alarm_status_regs framer_status_chk #(.E3_AIS_ONES(E3_AIS_ONES)) chk_i (
    .mclk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .cnt_evt,
    .counter_irq_pin_n, .reframe_start);

// *** tb/framer_alarm_status_regs_tb.sv ***
// self-checking bench of the framer status register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end

module framer_alarm_status_regs_tb;
    logic        mclk, rst = 1'b1, pin_n, refr, rx_raw, ack_o, dead = 1'b0;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [19:0] frm = 20'h0;
    logic [5:0]  cnt_evt = 6'h0;
    int          errors = 0, tests_run = 0, n;
    framer_alarm_status_regs #(.E3_AIS_ONES(8)) framer_alarm_status_regs_i (.mclk(mclk),
        .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_raw(rx_raw), .frm(frm),
        .cnt_evt(cnt_evt), .counter_irq_pin_n(pin_n), .reframe_start(refr));
    line_model line_model_i (.mclk(mclk), .dead(dead), .rx_raw(rx_raw));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****************************************************************
    // bus cycles and event pulses
    // ****************************************************************
    task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        int k;
        k = 0;
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        @(posedge mclk);
        while (ack_o !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (k >= 20) begin errors++; summarize(); end
    endtask
    task automatic rd(input logic [7:0] a, e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK($sformatf("reg %h", a), e, q)
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic fev(input logic [19:0] v);
        frm <= v;
        @(posedge mclk);
        frm <= 20'h0;
        @(posedge mclk);
    endtask
    task automatic cev(input logic [5:0] v);
        cnt_evt <= v;
        @(posedge mclk);
        cnt_evt <= 6'h0;
        @(posedge mclk);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        rd(8'h40, 8'hc0);
        rd(8'h44, 8'h00);
        wr(8'h08, 8'h3f);
        rd(8'h08, 8'h3f);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'hc0);
        wr(8'h7c, 8'hff);
        rd(8'h7c, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_cnt;
        for (int i = 0; i < 6; i++) begin
            cev(6'(1 << i));
            repeat (2) @(posedge mclk);
            `CHK("pin", 1'b0, pin_n)
            rd(8'h44, 8'(1 << i));
            rd(8'h44, 8'h00);
            `CHK("pin", 1'b1, pin_n)
        end
        wr(8'h08, 8'h00);
        cev(6'h01);
        rd(8'h44, 8'h01);
        `CHK("pin", 1'b1, pin_n)
        $display("test counters done");
    endtask
    task automatic t_los;
        dead <= 1'b1;
        repeat (95) @(posedge mclk);
        rd(8'h40, 8'hc0);
        repeat (160) @(posedge mclk);
        rd(8'h40, 8'hc1);
        rd(8'h44, 8'h40);
        dead <= 1'b0;
        rd(8'h40, 8'hc1);
        repeat (600) @(posedge mclk);
        rd(8'h40, 8'hc0);
        $display("test loss done");
    endtask
    task automatic t_oof;
        wr(8'h60, 8'h01);
        fev(20'h00001);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 3; i++) fev(20'h00060);
        rd(8'h40, 8'h00);
        fev(20'h00060);
        n = 0;
        while (refr !== 1'b1 && n < 5) begin @(posedge mclk); n++; end
        `CHK("reframe", 1'b1, refr)
        rd(8'h40, 8'h82);
        $display("test frame done");
    endtask
    task automatic t_alarm;
        fev(20'h00001);
        fev(20'h00018);
        rd(8'h40, 8'h08);
        for (int i = 0; i < 7; i++) fev(20'h00006);
        rd(8'h40, 8'h08);
        fev(20'h00006);
        rd(8'h40, 8'h04);
        wr(8'h60, 8'h00);
        fev(20'h2e000);
        rd(8'h40, 8'h00);
        fev(20'h32000);
        rd(8'h40, 8'h28);
        fev(20'h32000);
        rd(8'h40, 8'ha2);
        fev(20'h00001);
        fev(20'h22000);
        fev(20'h00380);
        fev(20'h00200);
        fev(20'h00300);
        fev(20'h00200);
        fev(20'h23c00);
        rd(8'h40, 8'h24);
        fev(20'h00380);
        fev(20'h00300);
        fev(20'h00200);
        fev(20'h00200);
        fev(20'h2f400);
        rd(8'h40, 8'h30);
        $display("test alarms done");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_cnt();
        t_los();
        t_oof();
        t_alarm();
        summarize();
    end
endmodule
